/* File: src/dag_top.sv */
/*
  dual data address generators with program-memory extension register path.
  assumes core-side inputs are synchronous to ref_clk and change only on its edges.
*/
// Function
// - Each generator holds and updates four index pointers plus modify and length values.
// - After an indirect access the used pointer adds one of four modify values.
// - A pointer with a length value is post-modified inside a circular buffer.
// - The primary generator makes only data addresses and can bit-reverse them.
// - The secondary generator makes program or data addresses and never bit-reverses.
// - Both generators work in the same cycle so two operands can be fetched at once.
// - A 16-bit write to program memory takes its low byte from the extension register.
// - A data read from program memory loads its low byte into the extension register.
// - An operand read from program memory and the next fetch happen in one cycle.
// - The serial port can use the circular addressing to move words to and from memory.
`timescale 1ns/10ps
`default_nettype none
module dag_top
  import dag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire dag_req_t pri_req,
  input wire dag_req_t sec_req,
  input wire dag_wr_t reg_wr,
  input wire dag_sp_req_t sp_req,
  input wire logic fetch_en,
  input wire logic [13:0] fetch_addr,
  input wire logic pm_rd_operand,
  input wire logic [23:0] pm_rd_data,
  input wire logic pm_wr_en,
  input wire logic [15:0] pm_wr_reg,
  input wire logic px_wr_en,
  input wire logic [7:0] px_wr_data,
  output dag_addr_t pri_addr_q,
  output dag_addr_t sec_addr_q,
  output dag_addr_t sp_addr_q,
  output logic [13:0] fetch_addr_q,
  output logic fetch_valid_q,
  output logic [15:0] pm_rd_reg_q,
  output logic pm_rd_valid_q,
  output logic [23:0] pm_wr_data_q,
  output logic pm_wr_valid_q,
  output logic [7:0] px_q
);

  logic [13:0] i_q [DAG_NG][DAG_NP];
  logic [13:0] i_d [DAG_NG][DAG_NP];
  logic [13:0] b_q [DAG_NG][DAG_NP];
  logic [13:0] b_d [DAG_NG][DAG_NP];
  logic [13:0] m_q [DAG_NG][DAG_NP];
  logic [13:0] m_d [DAG_NG][DAG_NP];
  logic [13:0] l_q [DAG_NG][DAG_NP];
  logic [13:0] l_d [DAG_NG][DAG_NP];
  dag_addr_t pri_addr_d;
  dag_addr_t sec_addr_d;
  dag_addr_t sp_addr_d;
  logic sp_grant;
  logic [7:0] px_d;
  logic [15:0] pm_rd_reg_d;
  logic pm_rd_valid_d;
  logic [23:0] pm_wr_data_d;
  logic pm_wr_valid_d;

  // post-modify with optional wrap; offset is taken against the buffer base
  // so a negative modify that underflows shows up as a large offset
  function automatic logic [13:0] dag_post_mod(input logic [13:0] ptr, input logic [13:0] mv,
                                                input logic [13:0] len, input logic [13:0] base);
    logic [13:0] nxt;
    logic [13:0] off;
    nxt = ptr + mv;
    off = nxt - base;
    dag_post_mod = nxt;
    if (len != DAG_RST_VAL && off >= len) begin
      if (mv[13]) begin
        dag_post_mod = nxt + len;
      end else begin
        dag_post_mod = nxt - len;
      end
    end
  endfunction : dag_post_mod

  function automatic logic [13:0] dag_bit_rev(input logic [13:0] a);
    for (int k = 0; k < DAG_AW; k++) begin
      dag_bit_rev[k] = a[DAG_AW - 1 - k];
    end
  endfunction : dag_bit_rev

  // serial port only steals a generator the core leaves idle this cycle
  always_comb begin
    sp_grant = sp_req.valid && !(sp_req.gen ? sec_req.valid : pri_req.valid);
  end

  // pointer file next state
  always_comb begin
    i_d = i_q;
    b_d = b_q;
    m_d = m_q;
    l_d = l_q;
    for (int g = 0; g < DAG_NG; g++) begin
      dag_req_t r;
      r = (g == 0) ? pri_req : sec_req;
      if (r.valid) begin
        i_d[g][r.ptr] = dag_post_mod(i_q[g][r.ptr], m_q[g][r.mods], l_q[g][r.ptr],
                                     b_q[g][r.ptr]);
      end
    end
    if (sp_grant) begin
      i_d[sp_req.gen][sp_req.ptr] = dag_post_mod(i_q[sp_req.gen][sp_req.ptr],
        m_q[sp_req.gen][sp_req.mods], l_q[sp_req.gen][sp_req.ptr],
        b_q[sp_req.gen][sp_req.ptr]);
    end
    // core load wins over a same-cycle update; an index load also sets the base
    if (reg_wr.en) begin
      case (reg_wr.kind)
        DAG_REG_I: begin
          i_d[reg_wr.gen][reg_wr.sel] = reg_wr.data;
          b_d[reg_wr.gen][reg_wr.sel] = reg_wr.data;
        end
        DAG_REG_M: m_d[reg_wr.gen][reg_wr.sel] = reg_wr.data;
        DAG_REG_L: l_d[reg_wr.gen][reg_wr.sel] = reg_wr.data;
        default: ;
      endcase
    end
  end

  // address outputs
  always_comb begin
    // primary is data space only, reversal on request
    pri_addr_d.valid = pri_req.valid;
    pri_addr_d.space = DAG_SPACE_DM;
    pri_addr_d.addr = pri_req.brev ? dag_bit_rev(i_q[0][pri_req.ptr]) : i_q[0][pri_req.ptr];
    sec_addr_d.valid = sec_req.valid;
    sec_addr_d.space = sec_req.to_pm ? DAG_SPACE_PM : DAG_SPACE_DM;
    sec_addr_d.addr = i_q[1][sec_req.ptr];
    sp_addr_d.valid = sp_grant;
    sp_addr_d.space = DAG_SPACE_DM;
    sp_addr_d.addr = i_q[sp_req.gen][sp_req.ptr];
  end

  // extension register path
  always_comb begin
    px_d = px_q;
    pm_rd_reg_d = pm_rd_reg_q;
    pm_rd_valid_d = pm_rd_operand;
    // low byte comes from the extension register
    pm_wr_data_d = pm_wr_en ? {pm_wr_reg, px_q} : pm_wr_data_q;
    pm_wr_valid_d = pm_wr_en;
    if (px_wr_en) begin
      px_d = px_wr_data;
    end
    // operand reads capture the low byte; instruction fetches never do
    if (pm_rd_operand) begin
      px_d = pm_rd_data[7:0];
      pm_rd_reg_d = pm_rd_data[23:8];
    end
  end

  // registers; ce low freezes everything
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int g = 0; g < DAG_NG; g++) begin
        for (int p = 0; p < DAG_NP; p++) begin
          i_q[g][p] <= DAG_RST_VAL;
          b_q[g][p] <= DAG_RST_VAL;
          m_q[g][p] <= DAG_RST_VAL;
          l_q[g][p] <= DAG_RST_VAL;
        end
      end
      pri_addr_q <= '0;
      sec_addr_q <= '0;
      sp_addr_q <= '0;
      fetch_addr_q <= DAG_RST_VAL;
      fetch_valid_q <= 1'b0;
      px_q <= DAG_PX_RST;
      pm_rd_reg_q <= 16'h0000;
      pm_rd_valid_q <= 1'b0;
      pm_wr_data_q <= 24'h000000;
      pm_wr_valid_q <= 1'b0;
    end else if (ce) begin
      i_q <= i_d;
      b_q <= b_d;
      m_q <= m_d;
      l_q <= l_d;
      pri_addr_q <= pri_addr_d;
      sec_addr_q <= sec_addr_d;
      sp_addr_q <= sp_addr_d;
      // fetch issued alongside the operand address
      fetch_addr_q <= fetch_en ? fetch_addr : fetch_addr_q;
      fetch_valid_q <= fetch_en;
      px_q <= px_d;
      pm_rd_reg_q <= pm_rd_reg_d;
      pm_rd_valid_q <= pm_rd_valid_d;
      pm_wr_data_q <= pm_wr_data_d;
      pm_wr_valid_q <= pm_wr_valid_d;
    end
  end

  // checks
  logic [13:0] i00_q;
  assign i00_q = i_q[0][0];

  plain_add_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && pri_req.valid && pri_req.ptr == 2'h0 && l_q[0][0] == 14'h0000 && !reg_wr.en
     && !sp_grant) |=> (i00_q == $past(i_q[0][0]) + $past(m_q[0][pri_req.mods])))
    else $error("plain post-modify wrong");
  // watches secondary pointer one, the buffer that normal traffic wraps
  wrap_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && sec_req.valid && sec_req.ptr == 2'h1 && l_q[1][1] != 14'h0000 && !reg_wr.en
     && !sp_grant && (i_q[1][1] - b_q[1][1]) < l_q[1][1])
    |=> ((i_q[1][1] - b_q[1][1]) < l_q[1][1]))
    else $error("circular pointer left its buffer");
  pri_space_a: assert property (@(posedge ref_clk) disable iff (rst)
    pri_addr_q.space == DAG_SPACE_DM)
    else $error("primary generator left data space");
  pri_rev_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && pri_req.valid && pri_req.brev)
    |=> (pri_addr_q.addr == dag_bit_rev($past(i_q[0][pri_req.ptr]))))
    else $error("bit-reversed address wrong");
  sec_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && sec_req.valid) |=> (sec_addr_q.valid && sec_addr_q.addr == $past(i_q[1][sec_req.ptr])
     && sec_addr_q.space == $past(sec_req.to_pm)))
    else $error("secondary address wrong");
  dual_issue_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && pri_req.valid && sec_req.valid) |=> (pri_addr_q.valid && sec_addr_q.valid))
    else $error("generators did not issue together");
  px_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && pm_wr_en) |=> (pm_wr_valid_q && pm_wr_data_q == {$past(pm_wr_reg), $past(px_q)}))
    else $error("program write low byte wrong");
  px_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && pm_rd_operand) |=> (px_q == $past(pm_rd_data[7:0]) && pm_rd_valid_q))
    else $error("extension register not loaded");
  fetch_pair_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && fetch_en && sec_req.valid && sec_req.to_pm)
    |=> (fetch_valid_q && sec_addr_q.space == DAG_SPACE_PM))
    else $error("fetch and operand not paired");
  sp_grant_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && sp_req.valid && !sp_req.gen && !pri_req.valid) |=> sp_addr_q.valid)
    else $error("serial request not served");

endmodule : dag_top
`default_nettype wire

/* File: src/dag_pkg.sv */
/*
  shared types and constants for the dual data address generators.
  assumes a single core clock and a core that drives all requests synchronously.
*/
package dag_pkg;
  // address width covers the full 16k-word program and data spaces
  localparam int DAG_AW = 14;
  localparam int DAG_NG = 2;
  localparam int DAG_NP = 4;
  localparam int DAG_DW = 16;
  localparam int DAG_PXW = 8;
  localparam int DAG_PMW = 24;
  // selects which register file a core write targets
  localparam logic [1:0] DAG_REG_I = 2'h0;
  localparam logic [1:0] DAG_REG_M = 2'h1;
  localparam logic [1:0] DAG_REG_L = 2'h2;
  localparam logic [13:0] DAG_RST_VAL = 14'h0000;
  localparam logic [7:0] DAG_PX_RST = 8'h00;
  localparam logic DAG_SPACE_DM = 1'b0;
  localparam logic DAG_SPACE_PM = 1'b1;

  // one indirect access request from the core
  typedef struct packed {
    logic valid;
    logic [1:0] ptr;
    logic [1:0] mods;
    logic brev;
    logic to_pm;
  } dag_req_t;

  // core write of an index, modify or length register
  typedef struct packed {
    logic en;
    logic gen;
    logic [1:0] kind;
    logic [1:0] sel;
    logic [13:0] data;
  } dag_wr_t;

  // serial port autobuffer request
  typedef struct packed {
    logic valid;
    logic gen;
    logic [1:0] ptr;
    logic [1:0] mods;
  } dag_sp_req_t;

  // one generated address
  typedef struct packed {
    logic valid;
    logic space;
    logic [13:0] addr;
  } dag_addr_t;
endpackage : dag_pkg

/* File: dv/dag_pm_model.sv */
/* program memory model answering the secondary generator's reads.
   assumes addresses arrive registered from the dut on ref_clk. */
`timescale 1ns/10ps
`default_nettype none
module dag_pm_model
  import dag_pkg::*;
(
  input wire logic ref_clk,
  input wire dag_addr_t addr_in,
  output logic [23:0] rd_data
);
  logic [23:0] rd_q = 24'h000000;
  // synchronous word; idle cycles toggle so stale data matches only after an even count of them
  always @(posedge ref_clk) begin
    if (addr_in.valid && addr_in.space == DAG_SPACE_PM) begin
      rd_q <= {addr_in.addr[7:0], addr_in.addr, 2'h3};
    end else begin
      rd_q <= ~rd_q;
    end
  end
  assign rd_data = rd_q;
endmodule : dag_pm_model
`default_nettype wire

/* File: dv/tb_dsp_data_address_generators.sv */
/* self-checking bench for the dual address generators.
   assumes dag_top and dag_pm_model are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
module tb_dsp_data_address_generators import dag_pkg::*;;
  logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1;
  dag_req_t pri_req = '0, sec_req = '0;
  dag_wr_t reg_wr = '0;
  dag_sp_req_t sp_req = '0;
  logic fetch_en = 1'b0, pm_rd_operand = 1'b0, pm_wr_en = 1'b0, px_wr_en = 1'b0;
  logic [13:0] fetch_addr = 14'h0000, fetch_addr_q;
  logic [15:0] pm_wr_reg = 16'h0000, pm_rd_reg_q;
  logic [7:0] px_wr_data = 8'h00, px_q;
  logic [23:0] pm_rd_data, pm_wr_data_q;
  dag_addr_t pri_addr_q, sec_addr_q, sp_addr_q;
  logic fetch_valid_q, pm_rd_valid_q, pm_wr_valid_q;
  int err_count = 0, samples_checked = 0, cycles = 0;

  dag_top i_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .pri_req(pri_req),
    .sec_req(sec_req), .reg_wr(reg_wr), .sp_req(sp_req), .fetch_en(fetch_en),
    .fetch_addr(fetch_addr), .pm_rd_operand(pm_rd_operand), .pm_rd_data(pm_rd_data),
    .pm_wr_en(pm_wr_en), .pm_wr_reg(pm_wr_reg), .px_wr_en(px_wr_en),
    .px_wr_data(px_wr_data), .pri_addr_q(pri_addr_q), .sec_addr_q(sec_addr_q),
    .sp_addr_q(sp_addr_q), .fetch_addr_q(fetch_addr_q), .fetch_valid_q(fetch_valid_q),
    .pm_rd_reg_q(pm_rd_reg_q), .pm_rd_valid_q(pm_rd_valid_q),
    .pm_wr_data_q(pm_wr_data_q), .pm_wr_valid_q(pm_wr_valid_q), .px_q(px_q));
  dag_pm_model i_mem (.ref_clk(ref_clk), .addr_in(sec_addr_q), .rd_data(pm_rd_data));

  // clock and hang guard
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic g, input logic [1:0] k, s, input logic [13:0] d);
    @(posedge ref_clk);
    reg_wr <= '{1'b1, g, k, s, d};
    @(posedge ref_clk);
    reg_wr <= '0;
  endtask : wr

  // one indirect access; checks the pre-modify address a cycle later
  task automatic acc(input logic g, input logic [1:0] p, m, input logic b, pm,
                     input logic [13:0] ea);
    dag_addr_t o;
    @(posedge ref_clk);
    if (g) sec_req <= '{1'b1, p, m, b, pm};
    else pri_req <= '{1'b1, p, m, b, pm};
    @(posedge ref_clk);
    pri_req <= '0;
    sec_req <= '0;
    #1;
    o = g ? sec_addr_q : pri_addr_q;
    chk({8'h00, o}, {9'h001, g & pm, ea});
  endtask : acc

  task automatic t_lin();
    wr(0, DAG_REG_I, 0, 14'h0100);
    wr(0, DAG_REG_M, 1, 14'h0003);
    acc(0, 0, 1, 0, 0, 14'h0100);
    acc(0, 0, 1, 0, 0, 14'h0103);
    acc(0, 0, 1, 0, 0, 14'h0106);
    // a frozen edge must neither issue an address nor post-modify
    @(posedge ref_clk);
    ce <= 1'b0;
    pri_req <= '{1'b1, 2'h0, 2'h1, 1'b0, 1'b0};
    @(posedge ref_clk);
    ce <= 1'b1;
    pri_req <= '0;
    #1;
    chk({23'h000000, pri_addr_q.valid}, 24'h000000);
    acc(0, 0, 1, 0, 0, 14'h0109);
    $display("test lin done");
  endtask : t_lin

  // upper end wrap, then lower end wrap with a negative modify
  task automatic t_circ();
    wr(1, DAG_REG_I, 1, 14'h0200);
    wr(1, DAG_REG_L, 1, 14'h0004);
    wr(1, DAG_REG_M, 2, 14'h0003);
    acc(1, 1, 2, 0, 0, 14'h0200);
    acc(1, 1, 2, 0, 0, 14'h0203);
    acc(1, 1, 2, 0, 0, 14'h0202);
    wr(1, DAG_REG_I, 2, 14'h0300);
    wr(1, DAG_REG_L, 2, 14'h0003);
    wr(1, DAG_REG_M, 3, 14'h3fff);
    acc(1, 2, 3, 0, 0, 14'h0300);
    acc(1, 2, 3, 0, 0, 14'h0302);
    acc(1, 2, 3, 0, 0, 14'h0301);
    $display("test circ done");
  endtask : t_circ

  task automatic t_brev();
    wr(0, DAG_REG_I, 3, 14'h0001);
    wr(1, DAG_REG_I, 0, 14'h0001);
    acc(0, 3, 0, 1, 1, 14'h2000);
    acc(1, 0, 0, 1, 1, 14'h0001);
    wr(0, DAG_REG_I, 2, 14'h0055);
    wr(1, DAG_REG_I, 3, 14'h0066);
    @(posedge ref_clk);
    pri_req <= '{1'b1, 2'h2, 2'h0, 1'b0, 1'b0};
    sec_req <= '{1'b1, 2'h3, 2'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    pri_req <= '0;
    sec_req <= '0;
    #1;
    chk({8'h00, pri_addr_q}, 24'h008055);
    chk({8'h00, sec_addr_q}, 24'h00c066);
    $display("test brev dual done");
  endtask : t_brev

  // operand read, program-memory write and fetch all in one cycle
  task automatic t_px();
    wr(1, DAG_REG_I, 1, 14'h0123);
    @(posedge ref_clk);
    px_wr_en <= 1'b1;
    px_wr_data <= 8'ha5;
    @(posedge ref_clk);
    px_wr_en <= 1'b0;
    acc(1, 1, 0, 0, 1, 14'h0123);
    // program-space operand address issued in the same cycle as the fetch
    @(posedge ref_clk);
    {pm_rd_operand, pm_wr_en, fetch_en} <= 3'h7;
    sec_req <= '{1'b1, 2'h1, 2'h0, 1'b0, 1'b1};
    pm_wr_reg <= 16'h1234;
    fetch_addr <= 14'h0abc;
    @(posedge ref_clk);
    {pm_rd_operand, pm_wr_en, fetch_en} <= 3'h0;
    sec_req <= '0;
    #1;
    chk(pm_wr_data_q, 24'h1234a5);
    chk({pm_rd_reg_q, px_q}, 24'h23048f);
    chk({fetch_addr_q, 7'h00, fetch_valid_q, pm_rd_valid_q, pm_wr_valid_q},
        {14'h0abc, 10'h007});
    chk({8'h00, sec_addr_q}, 24'h00c123);
    $display("test px done");
  endtask : t_px

  // serial grant, then refusal while the core holds the generator
  task automatic t_sp();
    wr(0, DAG_REG_I, 0, 14'h0040);
    wr(0, DAG_REG_M, 2, 14'h0002);
    @(posedge ref_clk);
    sp_req <= '{1'b1, 1'b0, 2'h0, 2'h2};
    @(posedge ref_clk);
    pri_req <= '{1'b1, 2'h1, 2'h0, 1'b0, 1'b0};
    #1;
    chk({8'h00, sp_addr_q}, 24'h008040);
    @(posedge ref_clk);
    sp_req <= '0;
    pri_req <= '0;
    #1;
    chk({23'h000000, sp_addr_q.valid}, 24'h000000);
    acc(0, 0, 2, 0, 0, 14'h0042);
    $display("test sp done");
  endtask : t_sp

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk({16'h0000, px_q}, 24'h000000);
    t_lin();
    t_circ();
    t_brev();
    t_px();
    t_sp();
    end_of_test();
  end
endmodule : tb_dsp_data_address_generators
`default_nettype wire
